/* codec_ctl_consts.svh */
// constants for the codec power, instruction memory and receive control block
// assumes: included by bare name wherever offsets or counts are needed
`ifndef CODEC_CTL_CONSTS_SVH
`define CODEC_CTL_CONSTS_SVH

// serial frame: read flag, 4-bit address, 12-bit value
`define CSI_FRAME_BITS   5'd17
`define CSI_HEAD_BITS    5'd5

// register addresses
`define ADDR_POWER       4'hc
`define ADDR_RAM         4'hd
`define ADDR_RX_CTRL     4'he

// power control subaddresses (value bits 11:8)
`define SUB_AUX_ONE      4'h1
`define SUB_AUX_TWO      4'h2
`define SUB_AUX_THREE    4'h3
`define SUB_VB_TX        4'h4
`define SUB_VB_RX        4'h5
`define SUB_REFERENCE    4'h6
`define SUB_BB_RX        4'h8
`define SUB_BB_TX        4'h9
`define SUB_DEVICE       4'hf
`define POWER_ON_BIT     0

// ram interface subaddresses (value bits 11:10)
`define RSUB_LOW         2'h0
`define RSUB_HIGH        2'h1
`define RSUB_ADDRESS     2'h2
`define RSUB_EXCHANGE    2'h3

// reset values
`define POWER_RESET      9'h122
`define RX_CTRL_RESET    2'h0

// receive control field positions
`define RX_BW_BIT        1
`define RX_SAMP_BIT      0

// gain code fraction widths and unity codes
`define CALIB_FRAC       4
`define VOLUME_FRAC      5
`define CALIB_UNITY      6'h10
`define VOLUME_UNITY     6'h20

`endif

/* codec_ctl_pkg.sv */
// types shared by the serial port and the control register block
// assumes: no other package is needed
package codec_ctl_pkg;

    typedef struct packed {
        logic        read;
        logic [3:0]  addr;
        logic [11:0] data;
    } csi_frame_t;

    typedef struct packed {
        logic device;
        logic bb_tx;
        logic bb_rx;
        logic reference;
        logic vb_rx;
        logic vb_tx;
        logic aux_converter_three;
        logic aux_converter_two;
        logic aux_converter_one;
    } power_state_t;

    typedef struct packed {
        logic bw_double;
        logic samp_double;
    } rx_mode_t;

    typedef enum logic [1:0] {
        rate_271_khz,
        rate_135_khz,
        rate_542_khz
    } rx_rate_t;

endpackage

/* csi_serial_port.sv */
// control serial port: samples the pins on the master clock and frames words
// assumes: serial clock phases last at least three master clock periods
`timescale 1ns/100ps
`include "codec_ctl_consts.svh"

module csi_serial_port (
    // system
    input  wire logic                      clock,
    input  wire logic                      reset_n,
    // serial pins
    input  wire logic                      csi_clock,
    input  wire logic                      csi_select_n,
    input  wire logic                      csi_data_in,
    output logic                           csi_data_out,
    output logic                           csi_data_out_en,
    // answer shifted out in the next frame
    input  wire logic [11:0]               reply_word,
    // received word
    output codec_ctl_pkg::csi_frame_t      frame,
    output logic                           frame_valid
);

    ////////////////////////////////////////////////////////////////////////////
    logic [2:0]  pin_meta;
    logic [2:0]  pin_sync;
    logic        prev_clock;
    logic        prev_select_n;
    logic [4:0]  bit_count;
    logic [16:0] shift_in;
    logic [11:0] shift_out;
    logic        clock_rise;
    logic        frame_start;
    logic        frame_end;

    // pins pass two flops; only pin_sync is looked at
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta <= 3'h7;
            pin_sync <= 3'h7;
        end else begin
            pin_meta <= {csi_clock, csi_select_n, csi_data_in};
            pin_sync <= pin_meta;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            prev_clock    <= 1'b1;
            prev_select_n <= 1'b1;
        end else begin
            prev_clock    <= pin_sync[2];
            prev_select_n <= pin_sync[1];
        end
    end

    assign clock_rise  = pin_sync[2] & ~prev_clock & ~pin_sync[1];
    assign frame_start = ~pin_sync[1] & prev_select_n;
    assign frame_end   = pin_sync[1] & ~prev_select_n;

    ////////////////////////////////////////////////////////////////////////////
    // no power gating here: the port keeps running with every section down
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bit_count <= 5'h00;
            shift_in  <= 17'h00000;
        end else if (frame_start) begin
            bit_count <= 5'h00;
        end else if (clock_rise) begin
            shift_in <= {shift_in[15:0], pin_sync[0]};
            if (bit_count != 5'h1f) begin
                bit_count <= bit_count + 5'h01;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            frame_valid <= 1'b0;
            frame       <= '0;
        end else begin
            frame_valid <= frame_end && bit_count == `CSI_FRAME_BITS;
            if (frame_end && bit_count == `CSI_FRAME_BITS) begin
                frame <= shift_in;
            end
        end
    end

    // answer loaded at frame start so a word changing mid-frame cannot tear
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            shift_out       <= 12'h000;
            csi_data_out_en <= 1'b0;
        end else begin
            csi_data_out_en <= ~pin_sync[1] && bit_count >= `CSI_HEAD_BITS
                               && bit_count < `CSI_FRAME_BITS;
            if (frame_start) begin
                shift_out <= reply_word;
            end else if (clock_rise && bit_count >= `CSI_HEAD_BITS) begin
                shift_out <= {shift_out[10:0], 1'b0};
            end
        end
    end

    assign csi_data_out = shift_out[11];

endmodule

/* codec_power_instruction_memory_rx_control.sv */
// power, instruction memory and baseband receive control of the codec
// assumes: gain codes and pcm samples come from logic on the master clock
//
// Behaviour
// - gain code 0 is off; calibration unity at 010000, volume unity at 100000
// - top code 111111 gives about 11.90 or 5.88 dB; linear steps
// - power register 1100 decodes subaddress bits 11:8 into the sections
// - power write bit 0 clear powers down, set powers up; bits 7:1 ignored
// - aux two, reference and device default on; all others default off
// - baseband receive and transmit power are register flag OR enable pin
// - serial port keeps working with every section powered down
// - after total power-down a register write alone powers up again
// - ram register 1101 decodes bits 11:10: low, high, address, exchange
// - instruction address, data and exchange registers have no reset value
// - address never auto-increments; host rewrites it each location
// - instruction memory writes ignored unless voice transmit and receive are off
// - memory readback lags one location; first read is undefined
// - receive path offers 100 kHz zero-IF and 200 kHz near-zero-IF bandwidth
// - normal sampling runs at half master clock, double at full rate
// - register 1110 selects output rate 271, 135, 542 or 271 kHz
// - calibration reads code as two integer bits, volume as one
`timescale 1ns/100ps
`include "codec_ctl_consts.svh"

module codec_power_instruction_memory_rx_control #(
    parameter int RAM_WORDS = 512
) (
    // system
    input  wire logic                        clock,
    input  wire logic                        reset_n,
    // control serial pins
    input  wire logic                        csi_clock,
    input  wire logic                        csi_select_n,
    input  wire logic                        csi_data_in,
    output logic                             csi_data_out,
    output logic                             csi_data_out_en,
    // baseband enable pins
    input  wire logic                        rx_power_pin,
    input  wire logic                        tx_power_pin,
    // power state
    output codec_ctl_pkg::power_state_t      section_power,
    output logic                             bb_rx_active,
    output logic                             bb_tx_active,
    // voice processor side
    input  wire logic [8:0]                  instr_fetch_addr,
    output logic [15:0]                      instr_fetch_data,
    output logic [9:0]                       processor_exchange,
    // baseband receive
    output logic                             rx_sample_strobe,
    output codec_ctl_pkg::rx_rate_t          rx_output_rate,
    output logic                             zero_if_mode,
    output logic                             near_zero_if_mode,
    // gain stages: tx_calib_gain, rx_calib_gain, rx_user_volume, sidetone_gain
    input  wire logic [3:0][5:0]             gain_codes,
    input  wire logic [3:0][15:0]            pcm_in,
    output logic [3:0][17:0]                 pcm_out
);

    ////////////////////////////////////////////////////////////////////////////
    codec_ctl_pkg::csi_frame_t frame;
    codec_ctl_pkg::rx_mode_t   rx_ctrl;
    logic                      frame_valid;
    logic                      wr;
    logic                      rd;
    logic [11:0]               reply_word;
    logic                      rx_pin_meta;
    logic                      rx_pin_sync;
    logic                      tx_pin_meta;
    logic                      tx_pin_sync;
    logic                      ram_write_ok;
    logic [15:0]               instruction_memory [RAM_WORDS];
    logic [8:0]                instr_addr;
    logic [7:0]                instr_high;
    logic [15:0]               read_lag;
    logic [8:0]                next_power_mask;

    csi_serial_port u_csi (
        .clock           (clock),
        .reset_n         (reset_n),
        .csi_clock       (csi_clock),
        .csi_select_n    (csi_select_n),
        .csi_data_in     (csi_data_in),
        .csi_data_out    (csi_data_out),
        .csi_data_out_en (csi_data_out_en),
        .reply_word      (reply_word),
        .frame           (frame),
        .frame_valid     (frame_valid)
    );

    assign wr = frame_valid & ~frame.read;
    assign rd = frame_valid & frame.read;

    // subaddress to section mask, same bit order as power_state_t
    function automatic logic [8:0] section_mask(input logic [3:0] sub);
        logic [8:0] m;
        m = 9'h000;
        unique case (sub)
            `SUB_AUX_ONE:   m = 9'h001;
            `SUB_AUX_TWO:   m = 9'h002;
            `SUB_AUX_THREE: m = 9'h004;
            `SUB_VB_TX:     m = 9'h008;
            `SUB_VB_RX:     m = 9'h010;
            `SUB_REFERENCE: m = 9'h020;
            `SUB_BB_RX:     m = 9'h040;
            `SUB_BB_TX:     m = 9'h080;
            `SUB_DEVICE:    m = 9'h100;
            default:        m = 9'h000;
        endcase
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // power sections
    assign next_power_mask = section_mask(frame.data[11:8]);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            section_power <= `POWER_RESET;
        end else if (wr && frame.addr == `ADDR_POWER) begin
            // only bit 0 matters; device bit may be set again after total power-down
            section_power <= (section_power & ~next_power_mask)
                | (next_power_mask & {9{frame.data[`POWER_ON_BIT]}});
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_pin_meta <= 1'b0;
            tx_pin_meta <= 1'b0;
            rx_pin_sync <= 1'b0;
            tx_pin_sync <= 1'b0;
        end else begin
            rx_pin_meta <= rx_power_pin;
            tx_pin_meta <= tx_power_pin;
            rx_pin_sync <= rx_pin_meta;
            tx_pin_sync <= tx_pin_meta;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bb_rx_active <= 1'b0;
            bb_tx_active <= 1'b0;
        end else begin
            bb_rx_active <= section_power.bb_rx | rx_pin_sync;
            bb_tx_active <= section_power.bb_tx | tx_pin_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // instruction memory; no reset on these words by design
    assign ram_write_ok = ~section_power.vb_tx & ~section_power.vb_rx;

    always_ff @(posedge clock) begin
        if (wr && frame.addr == `ADDR_RAM) begin
            unique case (frame.data[11:10])
                `RSUB_LOW: begin
                    if (ram_write_ok) begin
                        instruction_memory[instr_addr] <= {instr_high, frame.data[7:0]};
                    end
                end
                `RSUB_HIGH: begin
                    if (ram_write_ok) begin
                        instr_high <= frame.data[7:0];
                    end
                end
                `RSUB_ADDRESS: begin
                    if (ram_write_ok) begin
                        instr_addr <= frame.data[8:0];
                    end
                end
                `RSUB_EXCHANGE: processor_exchange <= frame.data[9:0];
            endcase
        end
    end

    always_ff @(posedge clock) begin
        instr_fetch_data <= instruction_memory[instr_fetch_addr];
    end

    // readback hands out the previous fetch: memory needs one more clock
    always_ff @(posedge clock) begin
        if (rd && frame.addr == `ADDR_RAM && frame.data[11:10] == `RSUB_LOW) begin
            read_lag <= instruction_memory[instr_addr];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reply_word <= 12'h000;
        end else if (rd) begin
            unique case (frame.addr)
                `ADDR_POWER:   reply_word <= {3'h0, section_power};
                `ADDR_RX_CTRL: reply_word <= {10'h000, rx_ctrl};
                `ADDR_RAM: begin
                    unique case (frame.data[11:10])
                        `RSUB_LOW:      reply_word <= {4'h0, read_lag[7:0]};
                        `RSUB_HIGH:     reply_word <= {4'h0, read_lag[15:8]};
                        `RSUB_ADDRESS:  reply_word <= {3'h0, instr_addr};
                        `RSUB_EXCHANGE: reply_word <= {2'h0, processor_exchange};
                    endcase
                end
                default:       reply_word <= 12'h000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // baseband receive control
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_ctrl <= `RX_CTRL_RESET;
        end else if (wr && frame.addr == `ADDR_RX_CTRL) begin
            rx_ctrl.bw_double   <= frame.data[`RX_BW_BIT];
            rx_ctrl.samp_double <= frame.data[`RX_SAMP_BIT];
        end
    end

    assign zero_if_mode      = ~rx_ctrl.bw_double;
    assign near_zero_if_mode = rx_ctrl.bw_double;

    // 135 kHz combination is decoded but should never be chosen by the host
    always_comb begin
        unique case (rx_ctrl)
            2'b00:   rx_output_rate = codec_ctl_pkg::rate_271_khz;
            2'b01:   rx_output_rate = codec_ctl_pkg::rate_135_khz;
            2'b10:   rx_output_rate = codec_ctl_pkg::rate_542_khz;
            2'b11:   rx_output_rate = codec_ctl_pkg::rate_271_khz;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_sample_strobe <= 1'b0;
        end else begin
            rx_sample_strobe <= rx_ctrl.samp_double | ~rx_sample_strobe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // gain stages; outputs are wide enough that the top code never wraps
    function automatic logic [17:0] gain_scale(input logic signed [15:0] s,
                                               input logic [5:0] c,
                                               input logic calib);
        logic signed [22:0] p;
        p = s * $signed({1'b0, c});
        return calib ? p[21:`CALIB_FRAC] : p[22:`VOLUME_FRAC];
    endfunction

    for (genvar g = 0; g < 4; g++) begin : gain_stage
        always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
                pcm_out[g] <= 18'h00000;
            end else begin
                pcm_out[g] <= gain_scale(pcm_in[g], gain_codes[g], g < 2);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    chk_bb_rx_or: assert property (##1 bb_rx_active == $past(section_power.bb_rx | rx_pin_sync))
        else $error("baseband receive power is not flag or pin");
    chk_bb_tx_or: assert property (##1 bb_tx_active == $past(section_power.bb_tx | tx_pin_sync))
        else $error("baseband transmit power is not flag or pin");
    chk_power_write: assert property (wr && frame.addr == `ADDR_POWER
        && frame.data[11:8] == `SUB_VB_TX |=> section_power.vb_tx == $past(frame.data[0]))
        else $error("voice transmit power did not follow bit 0");
    chk_device_repower: assert property (wr && frame.addr == `ADDR_POWER
        && frame.data[11:8] == `SUB_DEVICE && frame.data[0] |=> section_power.device)
        else $error("device did not power up on write");
    chk_ram_gate: assert property (wr && frame.addr == `ADDR_RAM && !ram_write_ok
        && frame.data[11:10] == `RSUB_ADDRESS |=> $stable(instr_addr))
        else $error("address changed while voice sections powered");
    chk_no_increment: assert property (wr && frame.addr == `ADDR_RAM
        && frame.data[11:10] == `RSUB_LOW |=> $stable(instr_addr))
        else $error("instruction address moved after data write");
    chk_instruction_memory_store: assert property (wr && frame.addr == `ADDR_RAM && ram_write_ok
        && frame.data[11:10] == `RSUB_LOW |=> instruction_memory[instr_addr]
        == {$past(instr_high), $past(frame.data[7:0])})
        else $error("instruction word not stored");
    chk_sampler_half: assert property (!rx_ctrl.samp_double ##1 !rx_ctrl.samp_double
        |-> rx_sample_strobe != $past(rx_sample_strobe))
        else $error("normal sampling strobe not at half rate");
    chk_sampler_full: assert property (rx_ctrl.samp_double |=> rx_sample_strobe)
        else $error("double sampling strobe missed a cycle");
    chk_rx_ctrl_write: assert property (wr && frame.addr == `ADDR_RX_CTRL
        |=> rx_ctrl == $past(frame.data[1:0]))
        else $error("receive control not written");
    chk_gain_off: assert property (gain_codes[0] == 6'h00 |=> pcm_out[0] == 18'h00000)
        else $error("gain code zero did not mute");
    chk_unity_calib: assert property (gain_codes[1] == `CALIB_UNITY
        |=> pcm_out[1] == {{2{$past(pcm_in[1][15])}}, $past(pcm_in[1])})
        else $error("calibration unity code not unity");

    cov_device_down: cover property (wr && frame.addr == `ADDR_POWER
        && frame.data[11:8] == `SUB_DEVICE && !frame.data[0]);
    cov_instruction_memory_load: cover property (wr && frame.addr == `ADDR_RAM && ram_write_ok
        && frame.data[11:10] == `RSUB_LOW);
    cov_near_zero_if_mode_double: cover property (rx_ctrl == 2'b11);
    cov_read_frame: cover property (rd);

endmodule

/* csi_host_model.sv */
// host side of the control serial link: frames words, collects replies
// assumes: caller enters at a falling master clock edge
`timescale 1ns/100ps
module csi_host_model (
    // system
    input  wire logic        clock,
    // serial pins
    output logic             csi_clock,
    output logic             csi_select_n,
    output logic             csi_data_in,
    input  wire logic        csi_data_out,
    input  wire logic        csi_data_out_en,
    // answer carried by the last frame
    output logic [11:0]      reply
);
    initial begin
        csi_clock = 1'b0;
        csi_select_n = 1'b1;
        csi_data_in = 1'b0;
    end
    // phases of four clocks keep clear of the three-clock minimum
    task automatic xfer(input logic [16:0] word);
        csi_select_n = 1'b0;
        for (int i = 16; i >= 0; i--) begin
            csi_data_in = word[i];
            repeat (4) @(negedge clock);
            // an undriven answer line reads as unknown, so a missing enable fails the compare
            if (i < 12) reply[i] = csi_data_out_en ? csi_data_out : 1'bx;
            csi_clock = 1'b1;
            repeat (4) @(negedge clock);
            csi_clock = 1'b0;
        end
        repeat (4) @(negedge clock);
        csi_select_n = 1'b1;
        // released line must not keep showing the last bit
        csi_data_in = ~csi_data_in;
        repeat (8) @(negedge clock);
    endtask
endmodule

/* codec_power_instruction_memory_rx_control_tb.sv */
// bench for the codec power, instruction memory and receive control block
// assumes: csi_host_model frames the serial words; 10 MHz master clock
`timescale 1ns/100ps
`include "codec_ctl_consts.svh"
module codec_power_instruction_memory_rx_control_tb;
    logic                        clock, reset_n, rx_power_pin, tx_power_pin, s0;
    logic                        csi_clock, csi_select_n, csi_data_in, csi_data_out;
    logic                        bb_rx_active, bb_tx_active, rx_sample_strobe;
    logic                        zero_if_mode, near_zero_if_mode, csi_data_out_en;
    codec_ctl_pkg::power_state_t section_power;
    codec_ctl_pkg::rx_rate_t     rx_output_rate;
    logic [8:0]                  instr_fetch_addr, exp_pw;
    logic [15:0]                 instr_fetch_data;
    logic [9:0]                  processor_exchange;
    logic [11:0]                 reply, got;
    logic [3:0][5:0]             gain_codes;
    logic [3:0][15:0]            pcm_in;
    logic [3:0][17:0]            pcm_out;
    int                          n_errors, samples_checked;
    logic [3:0]                  subs [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hf};
    logic [5:0]                  codes [4] = '{6'h00, 6'h10, 6'h20, 6'h3f};

    codec_power_instruction_memory_rx_control DUT (.*);
    csi_host_model HOST (.*);

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [17:0] exp, input logic [17:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [11:0] d);
        HOST.xfer({1'b0, a, d});
    endtask
    // the answer rides in the next frame, a read of an unmapped address
    task automatic rd(input logic [3:0] a, input logic [11:0] d);
        HOST.xfer({1'b1, a, d});
        HOST.xfer({1'b1, 4'h0, 12'h000});
        got = reply;
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #3_000_000;
        n_errors++;
        final_report();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        n_errors = 0;
        samples_checked = 0;
        reset_n = 1'b0;
        rx_power_pin = 1'b0;
        tx_power_pin = 1'b0;
        instr_fetch_addr = 9'h005;
        gain_codes = '0;
        pcm_in = {4{16'h1000}};
        repeat (20) @(negedge clock);
        reset_n = 1'b1;
        check("power", 18'h00122, 18'(section_power));
        check("rate", 18'h0, 18'(rx_output_rate));
        rd(`ADDR_POWER, 12'h000);
        check("power_read", 18'h00122, 18'(got));
        wr(`ADDR_RAM, 12'h805);
        wr(`ADDR_RAM, 12'h4ab);
        wr(`ADDR_RAM, 12'h0cd);
        wr(`ADDR_RAM, 12'h806);
        wr(`ADDR_RAM, 12'h412);
        wr(`ADDR_RAM, 12'h034);
        wr(`ADDR_RAM, 12'hea5);
        check("exchange", 18'h2a5, 18'(processor_exchange));
        check("fetch", 18'habcd, 18'(instr_fetch_data));
        instr_fetch_addr = 9'h006;
        repeat (2) @(negedge clock);
        check("fetch", 18'h1234, 18'(instr_fetch_data));
        rd(`ADDR_RAM, 12'h800);
        check("address", 18'h006, 18'(got));
        wr(`ADDR_RAM, 12'h805);
        rd(`ADDR_RAM, 12'h000);
        wr(`ADDR_RAM, 12'h806);
        rd(`ADDR_RAM, 12'h000);
        check("readback", 18'h0cd, 18'(got));
        exp_pw = 9'h122;
        for (int i = 0; i < 9; i++) begin
            exp_pw[i] = 1'b1;
            wr(`ADDR_POWER, {subs[i], 8'h01});
            check("power_on", 18'(exp_pw), 18'(section_power));
        end
        wr(`ADDR_POWER, 12'h7fe);
        check("power_sub", 18'h001ff, 18'(section_power));
        wr(`ADDR_RAM, 12'h806);
        wr(`ADDR_RAM, 12'h4ff);
        wr(`ADDR_RAM, 12'h0ff);
        check("fetch_gated", 18'h1234, 18'(instr_fetch_data));
        for (int i = 0; i < 9; i++) begin
            exp_pw[i] = 1'b0;
            wr(`ADDR_POWER, {subs[i], 8'hfe});
            check("power_off", 18'(exp_pw), 18'(section_power));
        end
        wr(`ADDR_POWER, 12'hf01);
        rd(`ADDR_POWER, 12'h000);
        check("power_wake", 18'h00100, 18'(got));
        rx_power_pin = 1'b1;
        repeat (4) @(negedge clock);
        check("bb_active", 18'h1, 18'({bb_tx_active, bb_rx_active}));
        rx_power_pin = 1'b0;
        tx_power_pin = 1'b1;
        repeat (4) @(negedge clock);
        check("bb_active", 18'h2, 18'({bb_tx_active, bb_rx_active}));
        tx_power_pin = 1'b0;
        for (int v = 0; v < 4; v++) begin
            wr(`ADDR_RX_CTRL, 12'(v));
            check("rate", 18'(v == 3 ? 0 : v), 18'(rx_output_rate));
            check("if_mode", 18'(v[1] ? 1 : 2), 18'({zero_if_mode, near_zero_if_mode}));
            s0 = rx_sample_strobe;
            @(negedge clock);
            check("strobe", 18'(v[0] ? 3 : (s0 === 1'b1 ? 2 : 1)), 18'({s0, rx_sample_strobe}));
            rd(`ADDR_RX_CTRL, 12'h000);
            check("rx_read", 18'(v), 18'(got));
        end
        for (int c = 0; c < 4; c++) begin
            // sidetone held at unity on the top code so the receive chain cannot clip
            gain_codes = {c == 3 ? `VOLUME_UNITY : codes[c], {3{codes[c]}}};
            repeat (2) @(negedge clock);
            for (int s = 0; s < 4; s++) begin
                check("gain", 18'(gain_codes[s]) << (s < 2 ? 8 : 7), pcm_out[s]);
            end
        end
        final_report();
    end
endmodule
